// ---- src/acr_pkg.sv ----
// Constants and carrier types for the amplifier and comparator control block
package acr_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_CLOCK_GATE = 8'h00;
  localparam logic [7:0] OFS_AMP_CTL    = 8'h04;
  localparam logic [7:0] OFS_CMP_MODE   = 8'h08;
  localparam logic [7:0] OFS_IRQ_FLAGS  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;
  localparam logic [7:0] OFS_RESET_CTL  = 8'h14;

  // Field positions
  localparam int BIT_AMP_CLK_GATE  = 2;
  localparam int BIT_CMP_CLK_GATE  = 5;
  localparam int BIT_AMP_GROUND    = 3;
  localparam int BIT_AMP_GAIN_LO   = 0;
  localparam int BIT_CMP1_RUN      = 4;
  localparam int BIT_CMP0_RUN      = 0;
  localparam int BIT_CMP_HOLD_RST  = 5;

  // Masks of implemented bits; all others read as zero
  localparam logic [7:0] MSK_CLOCK_GATE = 8'h24;
  localparam logic [7:0] MSK_AMP_CTL    = 8'h0B;
  localparam logic [7:0] MSK_CMP_MODE   = 8'h11;
  localparam logic [7:0] MSK_IRQ        = 8'h03;
  localparam logic [7:0] MSK_RESET_CTL  = 8'h20;

  // Reset values
  localparam logic [7:0] RST_CLOCK_GATE = 8'h00;
  localparam logic [7:0] RST_AMP_CTL    = 8'h00;
  localparam logic [7:0] RST_CMP_MODE   = 8'h00;
  localparam logic [1:0] RST_IRQ_FLAGS  = 2'h0;
  localparam logic [7:0] RST_IRQ_MASK   = 8'h03;
  localparam logic [7:0] RST_RESET_CTL  = 8'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Amplifier settings towards the analog macro
  typedef struct packed {
    logic       clk_en;
    logic       ground_select;
    logic [1:0] gain;
  } acr_amp_cfg_t;

  // Comparator controls towards the analog macro
  typedef struct packed {
    logic       clk_en;
    logic       hold_reset;
    logic [1:0] run;
  } acr_cmp_ctl_t;

  // Bus channel states
  typedef enum logic {ACR_WS_COLLECT = 1'b0, ACR_WS_RESP = 1'b1} acr_wstate_t;
  typedef enum logic {ACR_RS_IDLE = 1'b0, ACR_RS_DATA = 1'b1} acr_rstate_t;

endpackage : acr_pkg

// ---- src/acr_sync2.sv ----
// Two-flop synchroniser for asynchronous comparator outputs
`timescale 1ns/10ps
module acr_sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } acr_sync_t;

  acr_sync_t st_ff;
  acr_sync_t nxt_st;

  // First stage feeds only the second stage
  always_comb begin
    nxt_st.meta = async_in;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.sync;

endmodule : acr_sync2

// ---- src/acr_event_flags.sv ----
// Sticky comparator request flags with edge capture and software write
`timescale 1ns/10ps
module acr_event_flags (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Comparator side
  input  wire logic [1:0] cmp_level,
  input  wire logic [1:0] cmp_active,
  // Software side
  input  wire logic       sw_we,
  input  wire logic [1:0] sw_data,
  output logic      [1:0] flags
);

  typedef struct packed {
    logic [1:0] prev;
    logic [1:0] flag;
  } acr_flag_t;

  acr_flag_t  st_ff;
  acr_flag_t  nxt_st;
  logic [1:0] nxt_flag;

  // Per comparator: a new edge wins over a software clear in the same cycle
  for (genvar i = 0; i < 2; i++) begin : g_flag
    assign nxt_flag[i] = (cmp_active[i] && cmp_level[i] && !st_ff.prev[i])
                       | (sw_we ? sw_data[i] : st_ff.flag[i]);
  end

  always_comb begin
    nxt_st.prev = cmp_level;
    nxt_st.flag = nxt_flag;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff.prev <= 2'h0;
      st_ff.flag <= acr_pkg::RST_IRQ_FLAGS;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flags = st_ff.flag;

endmodule : acr_event_flags

// ---- src/acr_ctl_regs.sv ----
// Register bank controlling the gain amplifier and the two comparators
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module acr_ctl_regs (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]           awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 awvalid,
  output logic                      awready,
  // AXI4-Lite write data
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  // AXI4-Lite write response
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // AXI4-Lite read address
  input  wire logic [7:0]           araddr,
  input  wire logic [2:0]           arprot,
  input  wire logic                 arvalid,
  output logic                      arready,
  // AXI4-Lite read data
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Analog macro side
  input  wire logic [1:0]           cmp_out_async,
  output acr_pkg::acr_amp_cfg_t     amp_cfg,
  output acr_pkg::acr_cmp_ctl_t     cmp_ctl,
  // Requests to the interrupt controller
  output logic [1:0]                cmp_irq_req
);

  typedef struct packed {
    logic [7:0]           clk_gate;
    logic [7:0]           amp_ctl;
    logic [7:0]           cmp_mode;
    logic [7:0]           irq_mask;
    logic [7:0]           rst_ctl;
    logic                 aw_got;
    logic [7:0]           aw_addr;
    logic                 w_got;
    logic [7:0]           w_data;
    logic                 w_lane0;
    acr_pkg::acr_wstate_t wstate;
    logic [1:0]           bresp;
    acr_pkg::acr_rstate_t rstate;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
  } acr_regs_t;

  acr_regs_t  st_ff;
  acr_regs_t  nxt_st;
  logic [1:0] cmp_sync;
  logic [1:0] cmp_active;
  logic [1:0] flags;
  logic       flag_we;
  logic [1:0] flag_wdata;
  logic       commit;
  logic       amp_open;
  logic       cmp_held;

  // Comparator outputs come from the analog side, so resynchronise
  acr_sync2 #(
    .WIDTH    (2)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (cmp_out_async),
    .sync_out (cmp_sync)
  );

  // Flags capture events even when masked so software can poll them
  acr_event_flags u_flags (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .cmp_level  (cmp_sync),
    .cmp_active (cmp_active),
    .sw_we      (flag_we),
    .sw_data    (flag_wdata),
    .flags      (flags)
  );

  // Read mux; unmapped addresses answer with an error and zero data
  function automatic logic [9:0] read_word(input logic [7:0] addr,
                                           input acr_regs_t  s,
                                           input logic [1:0] f);
    logic [9:0] res;
    res = {acr_pkg::RESP_OKAY, 8'h00};
    unique case (addr)
      acr_pkg::OFS_CLOCK_GATE: res[7:0] = s.clk_gate;
      acr_pkg::OFS_AMP_CTL:    res[7:0] = s.amp_ctl;
      acr_pkg::OFS_CMP_MODE:   res[7:0] = s.cmp_mode;
      acr_pkg::OFS_IRQ_FLAGS:  res[7:0] = {6'h00, f};
      acr_pkg::OFS_IRQ_MASK:   res[7:0] = s.irq_mask;
      acr_pkg::OFS_RESET_CTL:  res[7:0] = s.rst_ctl;
      default:                 res      = {acr_pkg::RESP_SLVERR, 8'h00};
    endcase
    return res;
  endfunction : read_word

  // Status of the gates seen by the rest of the logic
  assign amp_open = st_ff.clk_gate[acr_pkg::BIT_AMP_CLK_GATE];
  assign cmp_held = st_ff.rst_ctl[acr_pkg::BIT_CMP_HOLD_RST];
  assign commit   = (st_ff.wstate == acr_pkg::ACR_WS_COLLECT)
                  && st_ff.aw_got && st_ff.w_got;

  // A comparator only produces events while clocked, running, not in reset
  always_comb begin
    cmp_active[1] = st_ff.clk_gate[acr_pkg::BIT_CMP_CLK_GATE]
                  && st_ff.cmp_mode[acr_pkg::BIT_CMP1_RUN] && !cmp_held;
    cmp_active[0] = st_ff.clk_gate[acr_pkg::BIT_CMP_CLK_GATE]
                  && st_ff.cmp_mode[acr_pkg::BIT_CMP0_RUN] && !cmp_held;
  end

  // Handshake outputs straight from the state
  assign awready = !st_ff.aw_got && (st_ff.wstate == acr_pkg::ACR_WS_COLLECT);
  assign wready  = !st_ff.w_got && (st_ff.wstate == acr_pkg::ACR_WS_COLLECT);
  assign bvalid  = (st_ff.wstate == acr_pkg::ACR_WS_RESP);
  assign bresp   = st_ff.bresp;
  assign arready = (st_ff.rstate == acr_pkg::ACR_RS_IDLE);
  assign rvalid  = (st_ff.rstate == acr_pkg::ACR_RS_DATA);
  assign rdata   = {24'h000000, st_ff.rdata};
  assign rresp   = st_ff.rresp;

  // Next state: bus channels, register writes and reset effects
  always_comb begin
    logic       hit;
    logic [9:0] rd;
    nxt_st     = st_ff;
    flag_we    = 1'b0;
    flag_wdata = st_ff.w_data[1:0];
    hit        = 1'b1;
    rd         = read_word(araddr, st_ff, flags);
    // Address and data are taken independently, in either order
    if (awvalid && awready) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.w_got   = 1'b1;
      nxt_st.w_data  = wdata[7:0];
      nxt_st.w_lane0 = wstrb[0];
    end
    if (commit) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.wstate = acr_pkg::ACR_WS_RESP;
      unique case (st_ff.aw_addr)
        acr_pkg::OFS_CLOCK_GATE: begin
          if (st_ff.w_lane0) begin
            nxt_st.clk_gate = st_ff.w_data
                            & acr_pkg::MSK_CLOCK_GATE;
          end
        end
        acr_pkg::OFS_AMP_CTL: begin
          // Ignored silently while the amp clock is off, as the macro would
          if (st_ff.w_lane0 && amp_open) begin
            nxt_st.amp_ctl = st_ff.w_data & acr_pkg::MSK_AMP_CTL;
          end
        end
        acr_pkg::OFS_CMP_MODE: begin
          if (st_ff.w_lane0 && !cmp_held) begin
            nxt_st.cmp_mode = st_ff.w_data & acr_pkg::MSK_CMP_MODE;
          end
        end
        acr_pkg::OFS_IRQ_FLAGS: begin
          flag_we = st_ff.w_lane0;
        end
        acr_pkg::OFS_IRQ_MASK: begin
          if (st_ff.w_lane0) begin
            nxt_st.irq_mask = st_ff.w_data & acr_pkg::MSK_IRQ;
          end
        end
        acr_pkg::OFS_RESET_CTL: begin
          if (st_ff.w_lane0) begin
            nxt_st.rst_ctl = st_ff.w_data & acr_pkg::MSK_RESET_CTL;
          end
        end
        default: hit = 1'b0;
      endcase
      nxt_st.bresp = hit ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      nxt_st.wstate = acr_pkg::ACR_WS_COLLECT;
    end
    // Comparator reset clears its mode settings for as long as it is held
    if (cmp_held) begin
      nxt_st.cmp_mode = acr_pkg::RST_CMP_MODE;
    end
    // Read channel: data registered one edge after the address
    if (arvalid && arready) begin
      nxt_st.rstate = acr_pkg::ACR_RS_DATA;
      nxt_st.rdata  = rd[7:0];
      nxt_st.rresp  = rd[9:8];
    end else if (rvalid && rready) begin
      nxt_st.rstate = acr_pkg::ACR_RS_IDLE;
    end
  end

  // Single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff.clk_gate <= acr_pkg::RST_CLOCK_GATE;
      st_ff.amp_ctl  <= acr_pkg::RST_AMP_CTL;
      st_ff.cmp_mode <= acr_pkg::RST_CMP_MODE;
      st_ff.irq_mask <= acr_pkg::RST_IRQ_MASK;
      st_ff.rst_ctl  <= acr_pkg::RST_RESET_CTL;
      st_ff.aw_got   <= 1'b0;
      st_ff.aw_addr  <= 8'h00;
      st_ff.w_got    <= 1'b0;
      st_ff.w_data   <= 8'h00;
      st_ff.w_lane0  <= 1'b0;
      st_ff.wstate   <= acr_pkg::ACR_WS_COLLECT;
      st_ff.bresp    <= acr_pkg::RESP_OKAY;
      st_ff.rstate   <= acr_pkg::ACR_RS_IDLE;
      st_ff.rdata    <= 8'h00;
      st_ff.rresp    <= acr_pkg::RESP_OKAY;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs to the analog side, all taken from register bits
  assign amp_cfg.clk_en        = amp_open;
  assign amp_cfg.ground_select =
    st_ff.amp_ctl[acr_pkg::BIT_AMP_GROUND];
  assign amp_cfg.gain = st_ff.amp_ctl[acr_pkg::BIT_AMP_GAIN_LO +: 2];
  assign cmp_ctl.clk_en = st_ff.clk_gate[acr_pkg::BIT_CMP_CLK_GATE];
  assign cmp_ctl.hold_reset    = cmp_held;
  assign cmp_ctl.run[1] = st_ff.cmp_mode[acr_pkg::BIT_CMP1_RUN];
  assign cmp_ctl.run[0] = st_ff.cmp_mode[acr_pkg::BIT_CMP0_RUN];

  // Pending and unblocked requests reach the processor
  assign cmp_irq_req = flags & ~st_ff.irq_mask[1:0];

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic amp_commit;
  logic cmp_commit;
  logic gate_commit;
  assign amp_commit  = commit && st_ff.aw_addr == acr_pkg::OFS_AMP_CTL
                     && st_ff.w_lane0;
  assign cmp_commit  = commit && st_ff.aw_addr == acr_pkg::OFS_CMP_MODE
                     && st_ff.w_lane0;
  assign gate_commit = commit && st_ff.aw_addr == acr_pkg::OFS_CLOCK_GATE
                     && st_ff.w_lane0;

  AST_AMP_LOCKED: assert property (
    amp_commit && !amp_open |=> $stable(amp_cfg.gain)
      && $stable(amp_cfg.ground_select))
    else $error("amp setting changed while its clock was off");

  AST_CMP_CLOCK: assert property (
    gate_commit |=> cmp_ctl.clk_en == $past(st_ff.w_data[5]))
    else $error("comparator clock gate did not follow write");

  AST_AMP_GROUND: assert property (
    amp_commit && amp_open |=>
      amp_cfg.ground_select == $past(st_ff.w_data[3]))
    else $error("ground select did not follow write");

  AST_AMP_GAIN: assert property (
    amp_commit && amp_open |=> amp_cfg.gain == $past(st_ff.w_data[1:0]))
    else $error("gain code did not follow write");

  AST_CMP1_RUN: assert property (
    cmp_commit && !cmp_held |=>
      cmp_ctl.run[1] == $past(st_ff.w_data[4]))
    else $error("comparator 1 run bit did not follow write");

  AST_CMP0_RUN: assert property (
    cmp_commit && !cmp_held |=> cmp_ctl.run[0] == $past(st_ff.w_data[0]))
    else $error("comparator 0 run bit did not follow write");

  AST_FLAG_CAUSE: assert property (
    $rose(flags[0]) |-> $past(flag_we && flag_wdata[0])
      || $past(cmp_active[0] && cmp_sync[0]))
    else $error("request flag 0 set without a cause");

  AST_MASK_BLOCKS: assert property (
    st_ff.irq_mask[1] |-> !cmp_irq_req[1])
    else $error("masked request 1 forwarded");

  AST_HOLD_CLEARS: assert property (
    cmp_held ##1 cmp_held |-> cmp_ctl.run == 2'h0)
    else $error("comparator runs while held in reset");

  AST_EVENT_SETS: assert property (
    cmp_active[1] && cmp_sync[1] && !$past(cmp_sync[1]) && !flag_we
      ##1 cmp_active[1] |-> flags[1])
    else $error("comparator 1 event lost");

  AST_READ_ANSWER: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read answer not one cycle after address");

  // A new write must not be taken while its response is still waiting
  AST_WRITE_ANSWER: assert property (
    commit |=> bvalid && !awready && !wready)
    else $error("write response not one cycle after commit");

  AST_AMP_CLOCK: assert property (
    gate_commit |=>
      amp_cfg.clk_en == $past(st_ff.w_data[acr_pkg::BIT_AMP_CLK_GATE]))
    else $error("amp clock gate did not follow write");

  // Without a running comparator only software can raise its flag
  AST_GATED_NO_EVENT: assert property (
    !cmp_active[1] && !flag_we |=> !$rose(flags[1]))
    else $error("request flag 1 set by a stopped comparator");

  AST_FLAG_CLEAR: assert property (
    flag_we && !flag_wdata[0] && !(cmp_active[0] && cmp_sync[0]) |=>
      !flags[0])
    else $error("request flag 0 not cleared by software");

  AST_MASK_FORWARD: assert property (
    flags[0] && !st_ff.irq_mask[0] |-> cmp_irq_req[0])
    else $error("unmasked request 0 not forwarded");

  COV_AMP_WRITE: cover property (amp_commit && amp_open);
  COV_AMP_REFUSED: cover property (amp_commit && !amp_open);
  COV_FLAG_MASKED: cover property (flags[0] && st_ff.irq_mask[0]);
  COV_IRQ_OUT: cover property (cmp_irq_req[1]);
  COV_HELD_WRITE: cover property (cmp_commit && cmp_held);

endmodule : acr_ctl_regs

// ---- testbench/amp_and_comparator_control_regs_test.sv ----
// Self-checking bench for the amplifier and comparator control registers
`timescale 1ns/10ps
module amp_and_comparator_control_regs_test;
  logic                  aclk;
  logic                  aresetn;
  logic [7:0]            awaddr, araddr;
  logic [2:0]            awprot, arprot;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp, cmp_out_async, cmp_irq_req;
  acr_pkg::acr_amp_cfg_t amp_cfg;
  acr_pkg::acr_cmp_ctl_t cmp_ctl;
  int                    fails, comparisons;

  acr_ctl_regs dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cmp_out_async(cmp_out_async), .amp_cfg(amp_cfg), .cmp_ctl(cmp_ctl),
    .cmp_irq_req(cmp_irq_req)
  );

  // 25 MHz clock
  always #20 aclk = ~aclk;

  // Verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Compare a seen value with the expected one
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen,
               exp);
    end
  endtask : check

  // Bounded wait ran out: count it and stop the run
  task automatic hung(input string what);
    fails++;
    $display("MISMATCH t=%0t %s: no answer", $time, what);
    final_report();
  endtask : hung

  // AXI4-Lite write; address and data offered together, released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    bit         aw_seen;
    bit         w_seen;
    bit         b_seen;
    logic [1:0] resp;
    int         n;
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      // Readies are sampled mid-cycle, where they are settled for the edge
      @(negedge aclk);
      aw_seen = awvalid && awready;
      w_seen  = wvalid && wready;
      b_seen  = bvalid;
      resp    = bresp;
      @(posedge aclk);
      if (aw_seen) begin
        awvalid <= 1'b0;
      end
      if (w_seen) begin
        wvalid <= 1'b0;
      end
      if (b_seen) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      hung("write");
    end else begin
      check({30'h0, resp}, {30'h0, er}, "write response");
      // One idle edge so the next call never re-raises bready at once
      @(posedge aclk);
    end
  endtask : wr

  // AXI4-Lite read with check of data and response
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input logic [1:0] er);
    bit          ar_seen;
    bit          r_seen;
    logic [31:0] data;
    logic [1:0]  resp;
    int          n;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      // Answer sampled mid-cycle and taken at the following edge
      @(negedge aclk);
      ar_seen = arvalid && arready;
      r_seen  = rvalid;
      data    = rdata;
      resp    = rresp;
      @(posedge aclk);
      if (ar_seen) begin
        arvalid <= 1'b0;
      end
      if (r_seen) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      hung("read");
    end else begin
      check(data, {24'h000000, exp}, "read data");
      check({30'h0, resp}, {30'h0, er}, "read response");
      @(posedge aclk);
    end
  endtask : rd

  // Main sequence
  initial begin
    logic [1:0] gc;
    aclk = 1'b0; aresetn = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    awprot = 3'h0; arprot = 3'h0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; wdata = 32'h00000000;
    wstrb = 4'hF; cmp_out_async = 2'h0; fails = 0; comparisons = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, unmapped place
    rd(acr_pkg::OFS_CLOCK_GATE, 8'h00, acr_pkg::RESP_OKAY);
    rd(acr_pkg::OFS_IRQ_FLAGS, 8'h00, acr_pkg::RESP_OKAY);
    rd(acr_pkg::OFS_IRQ_MASK, 8'h03, acr_pkg::RESP_OKAY);
    rd(acr_pkg::OFS_RESET_CTL, 8'h00, acr_pkg::RESP_OKAY);
    rd(8'h18, 8'h00, acr_pkg::RESP_SLVERR);
    wr(8'h18, 8'hFF, acr_pkg::RESP_SLVERR);
    $display("test reset values done");
    // Amplifier writes ignored while its clock is off
    wr(acr_pkg::OFS_AMP_CTL, 8'h0B, acr_pkg::RESP_OKAY);
    rd(acr_pkg::OFS_AMP_CTL, 8'h00, acr_pkg::RESP_OKAY);
    check({28'h0, amp_cfg}, 32'h0, "amp locked");
    wr(acr_pkg::OFS_CLOCK_GATE, 8'h04, acr_pkg::RESP_OKAY);
    check({28'h0, amp_cfg}, 32'h8, "amp clock on");
    // Every gain code, ground select toggled alongside
    for (int g = 0; g < 4; g++) begin
      gc = g[1:0];
      wr(acr_pkg::OFS_AMP_CTL, {4'h0, gc[0], 1'b0, gc}, acr_pkg::RESP_OKAY);
      check({28'h0, amp_cfg}, {28'h0, 1'b1, gc[0], gc}, "amp cfg");
      rd(acr_pkg::OFS_AMP_CTL, {4'h0, gc[0], 1'b0, gc},
         acr_pkg::RESP_OKAY);
    end
    // Clock off again: last settings kept, new write dropped
    wr(acr_pkg::OFS_CLOCK_GATE, 8'h00, acr_pkg::RESP_OKAY);
    wr(acr_pkg::OFS_AMP_CTL, 8'h00, acr_pkg::RESP_OKAY);
    rd(acr_pkg::OFS_AMP_CTL, 8'h0B, acr_pkg::RESP_OKAY);
    // Byte lane 0 not strobed: write answered but dropped
    wstrb <= 4'h0;
    wr(acr_pkg::OFS_CLOCK_GATE, 8'h24, acr_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd(acr_pkg::OFS_CLOCK_GATE, 8'h00, acr_pkg::RESP_OKAY);
    check({28'h0, cmp_ctl}, 32'h0, "strobe off");
    $display("test amplifier done");
    // Comparator clock, run bits and hold reset
    wr(acr_pkg::OFS_CLOCK_GATE, 8'h20, acr_pkg::RESP_OKAY);
    check({28'h0, cmp_ctl}, 32'h8, "cmp clock");
    wr(acr_pkg::OFS_CMP_MODE, 8'h10, acr_pkg::RESP_OKAY);
    check({28'h0, cmp_ctl}, 32'hA, "cmp1 run");
    wr(acr_pkg::OFS_CMP_MODE, 8'h01, acr_pkg::RESP_OKAY);
    check({28'h0, cmp_ctl}, 32'h9, "cmp0 run");
    wr(acr_pkg::OFS_RESET_CTL, 8'h20, acr_pkg::RESP_OKAY);
    check({28'h0, cmp_ctl}, 32'hC, "cmp held");
    wr(acr_pkg::OFS_CMP_MODE, 8'h11, acr_pkg::RESP_OKAY);
    rd(acr_pkg::OFS_CMP_MODE, 8'h00, acr_pkg::RESP_OKAY);
    wr(acr_pkg::OFS_RESET_CTL, 8'h00, acr_pkg::RESP_OKAY);
    check({28'h0, cmp_ctl}, 32'h8, "cmp released");
    $display("test comparator control done");
    // Events: comparator 1 stopped, comparator 0 running, all masked
    wr(acr_pkg::OFS_CMP_MODE, 8'h01, acr_pkg::RESP_OKAY);
    wr(acr_pkg::OFS_IRQ_FLAGS, 8'h00, acr_pkg::RESP_OKAY);
    cmp_out_async <= 2'h3;
    repeat (6) @(posedge aclk);
    rd(acr_pkg::OFS_IRQ_FLAGS, 8'h01, acr_pkg::RESP_OKAY);
    check({30'h0, cmp_irq_req}, 32'h0, "masked request");
    wr(acr_pkg::OFS_IRQ_MASK, 8'h02, acr_pkg::RESP_OKAY);
    check({30'h0, cmp_irq_req}, 32'h1, "unmasked cmp0");
    // Comparator 1 running now, fresh rising edge
    cmp_out_async <= 2'h0;
    wr(acr_pkg::OFS_CMP_MODE, 8'h11, acr_pkg::RESP_OKAY);
    cmp_out_async <= 2'h2;
    repeat (6) @(posedge aclk);
    rd(acr_pkg::OFS_IRQ_FLAGS, 8'h03, acr_pkg::RESP_OKAY);
    check({30'h0, cmp_irq_req}, 32'h1, "cmp1 still blocked");
    wr(acr_pkg::OFS_IRQ_MASK, 8'h00, acr_pkg::RESP_OKAY);
    check({30'h0, cmp_irq_req}, 32'h3, "both forwarded");
    wr(acr_pkg::OFS_IRQ_FLAGS, 8'h00, acr_pkg::RESP_OKAY);
    rd(acr_pkg::OFS_IRQ_FLAGS, 8'h00, acr_pkg::RESP_OKAY);
    check({30'h0, cmp_irq_req}, 32'h0, "flags cleared");
    // Comparator clock stopped: edges must not set flags
    cmp_out_async <= 2'h0;
    wr(acr_pkg::OFS_CLOCK_GATE, 8'h00, acr_pkg::RESP_OKAY);
    cmp_out_async <= 2'h3;
    repeat (6) @(posedge aclk);
    rd(acr_pkg::OFS_IRQ_FLAGS, 8'h00, acr_pkg::RESP_OKAY);
    $display("test comparator events done");
    final_report();
  end
endmodule : amp_and_comparator_control_regs_test
